// ---- include/tbsc_pkg.sv ----
package tbsc_pkg;
   // Clocking: the reference clock and the nominal switching frequency.
   localparam int REF_CLK_KHZ = 10000;
   localparam int FSW_KHZ = 500;
   localparam int SW_DIV = REF_CLK_KHZ / FSW_KHZ;
   // Counts in switching cycles, and the number of converters.
   localparam int OC_WAIT_CYC = 256;
   localparam int HICCUP_CYC = 8192;
   localparam int PG_FALL_CYC = 112;
   localparam int PG_RISE_CYC = 616;
   localparam int NCONV = 3;
   // Buck2 voltage code.
   localparam int VCODE_W = 7;
   localparam int VCODE_MIN_MV = 680;
   localparam int VCODE_STEP_MV = 10;
   localparam int MV_W = 12;
   // Register map, byte addresses.
   localparam int AW = 8;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CODE = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_TARGET = 8'h0C;
   // Field positions.
   localparam int CTRL_EN_LSB = 0;
   localparam int CTRL_SKIPDIS_LSB = 4;
   localparam int CODE_APPLY_BIT = 8;
   localparam int STAT_PG_LSB = 0;
   localparam int STAT_OC_LSB = 3;
   localparam int STAT_THERM_BIT = 6;
   localparam int STAT_PINONLY_BIT = 7;
   localparam int STAT_INTFB_BIT = 8;
   localparam int TARGET_MV_LSB = 16;
   // Reset values.
   localparam logic [2:0] CTRL_EN_RST = 3'h7;
   localparam logic [2:0] CTRL_SKIPDIS_RST = 3'h0;
   localparam logic [6:0] CODE_RST = 7'h00;
endpackage

// ---- verilog/tbsc_ocp.sv ----
`timescale 1ns/100ps
module tbsc_ocp #(
   parameter int WAIT_CYC = 256,
   parameter int HIC_CYC = 8192
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Switching-cycle enable and overcurrent level
   input wire logic tick,
   input wire logic oc,
   // Converter held off
   output logic shut_r
);
   localparam int WW = $clog2(WAIT_CYC + 1);
   localparam int HW = $clog2(HIC_CYC);
   logic [WW-1:0] wait_r;
   logic [HW-1:0] hic_r;
   wire hic_end_w = (hic_r == HW'(HIC_CYC - 1));
   wire trip_w = oc && (wait_r == WW'(WAIT_CYC));

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wait_r <= '0;
         hic_r <= '0;
         shut_r <= 1'b0;
      end
      else if (tick)
      begin
         if (shut_r)
         begin
            hic_r <= hic_end_w ? '0 : hic_r + 1'b1; // [RULE_02]
            shut_r <= !hic_end_w; // [RULE_02]
         end
         else if (trip_w)
         begin
            shut_r <= 1'b1; // [RULE_01]
            wait_r <= '0;
         end
         else
            wait_r <= oc ? wait_r + 1'b1 : '0; // [RULE_01] [RULE_17]
      end
   end

   oc_trip_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_01]
      $rose(shut_r) |-> $past(wait_r) == WAIT_CYC && $past(oc))
      else $error("Overcurrent shutdown without the full wait count.");
   oc_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_17]
      (tick && !oc && !shut_r) |=> wait_r == 0)
      else $error("Overcurrent wait count kept after a clean cycle.");
   hiccup_len_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_02]
      $fell(shut_r) |-> $past(hic_r) == HIC_CYC - 1)
      else $error("Hiccup interval has the wrong length.");
   oc_shut_c: cover property (@(posedge ref_clk) disable iff (!resetn) $fell(shut_r));
endmodule // tbsc_ocp

// ---- verilog/tbsc_deglitch.sv ----
`timescale 1ns/100ps
module tbsc_deglitch #(
   parameter int RISE_CYC = 616,
   parameter int FALL_CYC = 112
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // Switching-cycle enable and raw level
   input wire logic tick,
   input wire logic raw,
   // Filtered level
   output logic out_r
);
   localparam int CW = $clog2(RISE_CYC + FALL_CYC);
   logic [CW-1:0] cnt_r;
   wire [CW-1:0] lim_w = raw ? CW'(RISE_CYC - 1) : CW'(FALL_CYC - 1);
   wire differ_w = raw != out_r;

   // A change must hold for the whole interval; any relapse restarts it.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end
      else if (!differ_w)
         cnt_r <= '0;
      else if (tick)
      begin
         if (cnt_r == lim_w)
         begin
            out_r <= raw; // [RULE_16]
            cnt_r <= '0;
         end
         else
            cnt_r <= cnt_r + 1'b1; // [RULE_16]
      end
   end

   pg_rise_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_16]
      $rose(out_r) |-> $past(cnt_r) == RISE_CYC - 1)
      else $error("Power good rose before its deglitch interval.");
   pg_fall_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_16]
      $fell(out_r) |-> $past(cnt_r) == FALL_CYC - 1)
      else $error("Power good fell before its deglitch interval.");
   pg_rise_c: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(out_r));
endmodule // tbsc_deglitch

// ---- verilog/tbsc_top.sv ----
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
// What this block does
// RULE_01: Shut a converter down after overcurrent persists beyond 256 switching cycles.
// RULE_02: After overcurrent shutdown hold off 8192 switching cycles, then restart.
// RULE_03: Buck2 voltage code takes effect only when the apply bit is written.
// RULE_04: Buck2 target is a 7-bit code, 0.68 V upward in 10 mV steps.
// RULE_05: Light-load skip mode is on by default; software may force continuous conduction.
// RULE_06: Both serial pins low means all serial accesses are refused.
// RULE_07: In pin-only mode enables come from pins and buck2 uses external feedback.
// RULE_08: Power good needs every converter regulating and the start-up sequence done.
// RULE_09: Overvoltage keeps the high-side switch off until the comparator clears.
// RULE_10: Over-temperature shuts all converters down; they restart when it clears.
// RULE_11: Bootstrap undervoltage pulls the switch node low to recharge the capacitor.
// RULE_12: Buck1 switches 180 degrees from buck2 and buck3, which share phase.
// RULE_13: An external sync clock aligns the switching cycle to its falling edge.
// RULE_14: Software reads per-converter power good, overcurrent and temperature warnings.
// RULE_15: Software enables or disables each converter, besides the enable pins.
// RULE_16: Power good falls after 112 and rises after 616 steady switching cycles.
// RULE_17: One overcurrent-free switching cycle clears the overcurrent wait count.
module tbsc_top #(
   parameter int HICCUP_CYCLES = tbsc_pkg::HICCUP_CYC,
   parameter int SW_DIVIDE = tbsc_pkg::SW_DIV
)(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tbsc_pkg::AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic sda_pin,
   input wire logic scl_pin,
   input wire logic frequency_set_pin,
   input wire logic [tbsc_pkg::NCONV-1:0] converter_enable_pin,
   // Analog indications
   input wire logic [tbsc_pkg::NCONV-1:0] overcurrent,
   input wire logic [tbsc_pkg::NCONV-1:0] overvoltage,
   input wire logic [tbsc_pkg::NCONV-1:0] in_regulation,
   input wire logic [tbsc_pkg::NCONV-1:0] bootstrap_uv,
   input wire logic [tbsc_pkg::NCONV-1:0] soft_start_done,
   input wire logic thermal_trip,
   // Converter control
   output logic [tbsc_pkg::NCONV-1:0] conv_run,
   output logic [tbsc_pkg::NCONV-1:0] high_side_block,
   output logic [tbsc_pkg::NCONV-1:0] switch_node_pull_low,
   output logic [tbsc_pkg::NCONV-1:0] light_load_skip_mode,
   output logic [tbsc_pkg::VCODE_W-1:0] voltage_code,
   output logic internal_fb_sel,
   output logic buck1_clk,
   output logic buck23_clk,
   output logic power_good_output
);
   import tbsc_pkg::*;

   localparam int SW = 2 + 1 + 6 * NCONV + 1;
   localparam int DW = $clog2(SW_DIVIDE + 1);

   // Every pin and analog level passes two flops before use.
   wire [SW-1:0] async_w = {sda_pin, scl_pin, frequency_set_pin, converter_enable_pin, overcurrent,
                            overvoltage, in_regulation, bootstrap_uv, soft_start_done, thermal_trip};
   logic [SW-1:0] sync1_r;
   logic [SW-1:0] sync2_r;
   logic ext_d_r;
   logic [DW-1:0] div_r;
   logic [2:0] ctrl_en_r;
   logic [2:0] ctrl_skipdis_r;
   logic [VCODE_W-1:0] code_stage_r;
   logic [NCONV-1:0] oc_shut_w;
   logic pg_raw_r;

   wire sda_s = sync2_r[SW-1];
   wire scl_s = sync2_r[SW-2];
   wire ext_s = sync2_r[SW-3];
   wire [NCONV-1:0] en_pin_s = sync2_r[SW-4 -: NCONV];
   wire [NCONV-1:0] oc_s = sync2_r[SW-4-NCONV -: NCONV];
   wire [NCONV-1:0] ov_s = sync2_r[SW-4-2*NCONV -: NCONV];
   wire [NCONV-1:0] inreg_s = sync2_r[SW-4-3*NCONV -: NCONV];
   wire [NCONV-1:0] bst_s = sync2_r[SW-4-4*NCONV -: NCONV];
   wire [NCONV-1:0] ssd_s = sync2_r[SW-4-5*NCONV -: NCONV];
   wire therm_s = sync2_r[0];

   // Switching-cycle timebase; an external falling edge restarts the cycle.
   wire ext_fall_w = ext_d_r && !ext_s; // [RULE_13]
   wire div_end_w = (div_r == DW'(SW_DIVIDE - 1));
   wire tick_w = div_end_w || ext_fall_w;
   wire [DW-1:0] div_nxt = tick_w ? '0 : div_r + 1'b1; // [RULE_13]
   wire phase_hi_w = div_nxt < DW'(SW_DIVIDE / 2);

   // Floating or grounded serial pins both read low.
   wire pin_only_w = !sda_s && !scl_s; // [RULE_06]
   wire [NCONV-1:0] en_eff_w = pin_only_w ? en_pin_s : (en_pin_s & ctrl_en_r); // [RULE_07] [RULE_15]
   wire [NCONV-1:0] run_nxt = en_eff_w & ~oc_shut_w & {NCONV{!therm_s}}; // [RULE_10]

   // APB decode. Errors are decided in the setup phase and shown in the access phase.
   wire setup_w = psel && !penable;
   wire hit_w = (paddr == ADDR_CTRL) || (paddr == ADDR_CODE) || (paddr == ADDR_STAT)
                || (paddr == ADDR_TARGET);
   wire err_nxt = pin_only_w || !hit_w; // [RULE_06]
   wire wr_w = psel && penable && pwrite && pready && !pslverr;
   wire wr_ctrl_w = wr_w && (paddr == ADDR_CTRL);
   wire wr_code_w = wr_w && (paddr == ADDR_CODE);
   wire apply_w = wr_code_w && pwdata[CODE_APPLY_BIT]; // [RULE_03]
   wire [VCODE_W-1:0] code_in_w = pwdata[VCODE_W-1:0];

   // Buck2 target in millivolts for software: 680 mV plus 10 mV per step.
   wire [MV_W-1:0] target_mv_w = MV_W'(VCODE_MIN_MV) + MV_W'(VCODE_STEP_MV) * MV_W'(voltage_code); // [RULE_04]
   wire [NCONV-1:0] pg_each_w = inreg_s & conv_run;
   wire [NCONV-1:0] oc_warn_w = oc_s | oc_shut_w;
   wire [31:0] rd_ctrl_w = 32'(ctrl_en_r) << CTRL_EN_LSB | 32'(ctrl_skipdis_r) << CTRL_SKIPDIS_LSB;
   wire [31:0] rd_stat_w = 32'(pg_each_w) << STAT_PG_LSB | 32'(oc_warn_w) << STAT_OC_LSB // [RULE_14]
                           | 32'(therm_s) << STAT_THERM_BIT | 32'(pin_only_w) << STAT_PINONLY_BIT
                           | 32'(internal_fb_sel) << STAT_INTFB_BIT;
   wire [31:0] rd_target_w = 32'(voltage_code) | 32'(target_mv_w) << TARGET_MV_LSB;
   wire [31:0] rd_nxt = err_nxt ? 32'h0000_0000 :
                        (paddr == ADDR_CTRL) ? rd_ctrl_w :
                        (paddr == ADDR_CODE) ? 32'(code_stage_r) :
                        (paddr == ADDR_STAT) ? rd_stat_w : rd_target_w;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
         ext_d_r <= 1'b0;
         div_r <= '0;
      end
      else
      begin
         sync1_r <= async_w;
         sync2_r <= sync1_r;
         ext_d_r <= ext_s;
         div_r <= div_nxt;
      end
   end

   // Each switching-clock output is the other's complement, so they never share phase.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         buck23_clk <= 1'b1;
         buck1_clk <= 1'b0;
      end
      else
      begin
         buck23_clk <= phase_hi_w; // [RULE_12]
         buck1_clk <= !phase_hi_w; // [RULE_12]
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else
      begin
         pready <= 1'b1;
         if (setup_w)
         begin
            pslverr <= err_nxt; // [RULE_06]
            prdata <= rd_nxt; // [RULE_14]
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_en_r <= CTRL_EN_RST;
         ctrl_skipdis_r <= CTRL_SKIPDIS_RST;
         code_stage_r <= CODE_RST;
      end
      else
      begin
         if (wr_ctrl_w)
         begin
            ctrl_en_r <= pwdata[CTRL_EN_LSB +: NCONV]; // [RULE_15]
            ctrl_skipdis_r <= pwdata[CTRL_SKIPDIS_LSB +: NCONV]; // [RULE_05]
         end
         if (wr_code_w)
            code_stage_r <= code_in_w; // [RULE_04]
      end
   end

   // Loading the staged code alone leaves the output untouched; only apply moves it.
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         voltage_code <= CODE_RST;
         internal_fb_sel <= 1'b0;
      end
      else if (pin_only_w)
         internal_fb_sel <= 1'b0; // [RULE_07]
      else if (apply_w)
      begin
         voltage_code <= code_in_w; // [RULE_03]
         internal_fb_sel <= 1'b1; // [RULE_03]
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         conv_run <= '0;
         high_side_block <= '0;
         switch_node_pull_low <= '0;
         light_load_skip_mode <= '1;
         pg_raw_r <= 1'b0;
      end
      else
      begin
         conv_run <= run_nxt; // [RULE_01] [RULE_02] [RULE_10]
         high_side_block <= ov_s; // [RULE_09]
         switch_node_pull_low <= bst_s & run_nxt; // [RULE_11]
         light_load_skip_mode <= pin_only_w ? '1 : ~ctrl_skipdis_r; // [RULE_05]
         pg_raw_r <= &(inreg_s & run_nxt & ssd_s); // [RULE_08]
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NCONV; gi++)
      begin : g_ocp
         tbsc_ocp #(.WAIT_CYC(OC_WAIT_CYC), .HIC_CYC(HICCUP_CYCLES)) u_ocp (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .tick(tick_w),
            .oc(oc_s[gi]),
            .shut_r(oc_shut_w[gi])
         );
      end
   endgenerate

   tbsc_deglitch #(.RISE_CYC(PG_RISE_CYC), .FALL_CYC(PG_FALL_CYC)) u_pg (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .tick(tick_w),
      .raw(pg_raw_r),
      .out_r(power_good_output)
   );

   vcode_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_03]
      (wr_code_w && !pwdata[CODE_APPLY_BIT]) |=> $stable(voltage_code))
      else $error("Voltage code changed without an apply write.");
   vcode_apply_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_03]
      (apply_w && !pin_only_w) |=> voltage_code == $past(code_in_w) && internal_fb_sel)
      else $error("Apply write did not move the voltage code.");
   pin_refuse_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_06]
      (setup_w && pin_only_w) |=> pslverr ##0 (!penable || (penable && pready)))
      else $error("Serial access accepted in pin-only mode.");
   pin_fb_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_07]
      pin_only_w |=> !internal_fb_sel)
      else $error("Internal feedback kept in pin-only mode.");
   therm_off_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_10]
      therm_s |=> conv_run == '0)
      else $error("Converter running during over-temperature.");
   bst_low_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_11]
      $rose(|switch_node_pull_low) |-> $past(|bst_s))
      else $error("Switch node pulled low without bootstrap undervoltage.");
   phase_opp_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_12]
      buck1_clk != buck23_clk)
      else $error("Buck1 clock is in phase with buck2 and buck3.");
   ext_align_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_13]
      ext_fall_w |=> div_r == 0 ##1 div_r == 1)
      else $error("Switching cycle not aligned to the sync falling edge.");
   pg_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_08]
      $rose(power_good_output) |-> $past(pg_raw_r))
      else $error("Power good rose while a converter was out of regulation.");
   // Complementary clocks alone prove nothing about alignment, so also pin the cycle start.
   phase_start_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_12]
      tick_w |=> buck23_clk && !buck1_clk)
      else $error("Buck2 and buck3 clock not high at the start of a switching cycle.");
   skip_mode_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_05]
      (pin_only_w || ctrl_skipdis_r == '0) |=> &light_load_skip_mode)
      else $error("Light-load skip mode off without a software disable.");
   pin_enable_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_07]
      (pin_only_w && !therm_s && oc_shut_w == '0) |=> conv_run == $past(en_pin_s))
      else $error("Pin-only converter state differs from its enable pin.");
   sw_enable_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_15]
      !pin_only_w |=> (conv_run & ~$past(ctrl_en_r)) == '0)
      else $error("Converter running although software disabled it.");
   ov_block_a: assert property (@(posedge ref_clk) disable iff (!resetn) // [RULE_09]
      (|ov_s) |=> (high_side_block & $past(ov_s)) == $past(ov_s))
      else $error("High-side switch not blocked during overvoltage.");
   apply_c: cover property (@(posedge ref_clk) disable iff (!resetn) apply_w && !pin_only_w);
   pin_only_c: cover property (@(posedge ref_clk) disable iff (!resetn) setup_w && pin_only_w);
   ext_sync_c: cover property (@(posedge ref_clk) disable iff (!resetn) ext_fall_w);
endmodule // tbsc_top

// ---- testbench/tbsc_host_model.sv ----
`timescale 1ns/100ps
// Far-side host seen at the two serial pins. While attached, the idle bus sits at its pull-up level;
// when detached the pins are grounded, which is how the board selects pin-only operation.
module tbsc_host_model (
   // Board strap
   input wire logic attached,
   // Serial pins
   output logic sda_pin,
   output logic scl_pin
);
   assign sda_pin = attached;
   assign scl_pin = attached;
endmodule // tbsc_host_model

// ---- testbench/tbsc_top_test.sv ----
`timescale 1ns/100ps
module tbsc_top_test;
   import tbsc_pkg::*;
   logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, attached = 1;
   logic frequency_set_pin = 0, thermal_trip = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, sda_pin, scl_pin, internal_fb_sel, buck1_clk, buck23_clk, power_good_output;
   logic [2:0] converter_enable_pin = 3'h7, overcurrent = 3'h0, overvoltage = 3'h0;
   logic [2:0] in_regulation = 3'h7, bootstrap_uv = 3'h0, soft_start_done = 3'h7;
   logic [2:0] conv_run, high_side_block, switch_node_pull_low, light_load_skip_mode;
   logic [6:0] voltage_code;
   int miscompares = 0, n_compared = 0, cycles = 0;

   // Short hiccup and switching divider keep the run brief; expectations use these values.
   tbsc_top #(.HICCUP_CYCLES(16), .SW_DIVIDE(4)) u_tbsc_top (.ref_clk, .resetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sda_pin, .scl_pin, .frequency_set_pin,
      .converter_enable_pin, .overcurrent, .overvoltage, .in_regulation, .bootstrap_uv,
      .soft_start_done, .thermal_trip, .conv_run, .high_side_block, .switch_node_pull_low,
      .light_load_skip_mode, .voltage_code, .internal_fb_sel, .buck1_clk, .buck23_clk,
      .power_good_output);
   tbsc_host_model u_tbsc_host_model (.attached, .sda_pin, .scl_pin);

   always #50 ref_clk = ~ref_clk;

   task automatic results;
      $display("Compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Pready is registered, so the value read at the edge is the one the slave presented.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      chk(d, exp);
      chk(e, experr);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic experr);
      logic [31:0] d;
      logic e;
      apb(1'b1, a, wd, d, e);
      chk(e, experr);
   endtask

   task automatic t_power_good;
      cyc(2400);
      chk(power_good_output, 32'h0);
      cyc(120);
      chk(power_good_output, 32'h1);
      in_regulation <= 3'h5;
      cyc(400);
      chk(power_good_output, 32'h1);
      cyc(80);
      chk(power_good_output, 32'h0);
      rchk(ADDR_STAT, 32'h5, 1'b0);
      // Regulation is back but the start-up sequence is not done, so power good must stay low.
      soft_start_done <= 3'h3;
      in_regulation <= 3'h7;
      cyc(2500);
      chk(power_good_output, 32'h0);
      soft_start_done <= 3'h7;
   endtask

   task automatic t_regs;
      rchk(ADDR_CTRL, 32'h7, 1'b0);
      rchk(ADDR_TARGET, 32'h02A80000, 1'b0);
      rchk(8'h10, 32'h0, 1'b1);
      chk(light_load_skip_mode, 32'h7);
   endtask

   task automatic t_overcurrent;
      overcurrent <= 3'h1;
      cyc(800);
      overcurrent <= 3'h0;
      cyc(12);
      overcurrent <= 3'h1;
      cyc(1000);
      chk(conv_run, 32'h7);
      for (int i = 0; i < 80 && conv_run[0] !== 1'b0; i++) @(posedge ref_clk);
      chk(conv_run, 32'h6);
      rchk(ADDR_STAT, 32'hE, 1'b0);
      overcurrent <= 3'h0;
      cyc(40);
      chk(conv_run, 32'h6);
      cyc(40);
      chk(conv_run, 32'h7);
   endtask

   task automatic t_apply;
      wr(ADDR_CODE, 32'h7F, 1'b0);
      cyc(3);
      chk(voltage_code, 32'h0);
      chk(internal_fb_sel, 32'h0);
      wr(ADDR_CODE, 32'h17F, 1'b0);
      cyc(3);
      chk(voltage_code, 32'h7F);
      chk(internal_fb_sel, 32'h1);
      rchk(ADDR_TARGET, 32'h079E007F, 1'b0);
      rchk(ADDR_CODE, 32'h7F, 1'b0);
   endtask

   task automatic t_thermal;
      thermal_trip <= 1'b1;
      cyc(5);
      chk(conv_run, 32'h0);
      rchk(ADDR_STAT, 32'h140, 1'b0);
      thermal_trip <= 1'b0;
      cyc(5);
      chk(conv_run, 32'h7);
   endtask

   task automatic t_control;
      wr(ADDR_CTRL, 32'h55, 1'b0);
      cyc(4);
      chk(conv_run, 32'h5);
      chk(light_load_skip_mode, 32'h2);
      converter_enable_pin <= 3'h3;
      cyc(5);
      chk(conv_run, 32'h1);
      converter_enable_pin <= 3'h7;
      overvoltage <= 3'h4;
      bootstrap_uv <= 3'h1;
      cyc(5);
      chk(high_side_block, 32'h4);
      chk(switch_node_pull_low, 32'h1);
      overvoltage <= 3'h0;
      bootstrap_uv <= 3'h0;
      cyc(5);
      chk(high_side_block, 32'h0);
      chk(switch_node_pull_low, 32'h0);
   endtask

   task automatic t_phase;
      int toggles;
      logic last;
      toggles = 0;
      last = buck1_clk;
      repeat (40)
      begin
         @(posedge ref_clk);
         chk(buck1_clk ^ buck23_clk, 32'h1);
         if (buck1_clk !== last)
            toggles++;
         last = buck1_clk;
      end
      chk(toggles >= 2, 32'h1);
   endtask

   // A 6-cycle sync clock against the 4-cycle divider: each falling edge restarts the cycle,
   // so buck23_clk is high 4 of every 6 cycles instead of 2 of every 4 when free running.
   task automatic t_sync;
      int highs;
      highs = 0;
      for (int p = 0; p < 6; p++)
      begin
         frequency_set_pin <= 1'b1;
         repeat (3)
         begin
            @(posedge ref_clk);
            if (p >= 4)
               highs += buck23_clk;
         end
         frequency_set_pin <= 1'b0;
         repeat (3)
         begin
            @(posedge ref_clk);
            if (p >= 4)
               highs += buck23_clk;
         end
      end
      chk(highs, 32'h8);
   endtask

   task automatic t_pin_only;
      attached <= 1'b0;
      converter_enable_pin <= 3'h2;
      cyc(5);
      chk(conv_run, 32'h2);
      chk(internal_fb_sel, 32'h0);
      chk(light_load_skip_mode, 32'h7);
      rchk(ADDR_CTRL, 32'h0, 1'b1);
      wr(ADDR_CTRL, 32'h7, 1'b1);
      attached <= 1'b1;
      converter_enable_pin <= 3'h7;
      cyc(5);
      rchk(ADDR_CTRL, 32'h55, 1'b0);
   endtask

   initial
   begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      t_power_good();
      t_regs();
      t_overcurrent();
      t_apply();
      t_thermal();
      t_control();
      t_phase();
      t_sync();
      t_pin_only();
      results();
   end
endmodule // tbsc_top_test
